// file: rtl/fra_defines.svh
// Offsets, reset values, encodings and timing counts of the reciprocal seed unit.
`ifndef FRA_DEFINES_SVH
`define FRA_DEFINES_SVH

// -----------------------------------------------------------------------------
// Register map (Wishbone byte addresses)
// -----------------------------------------------------------------------------
`define FRA_REG_STATUS      8'h00
`define FRA_REG_MASK        8'h04
`define FRA_FLAGS_RESET     8'h00
`define FRA_MASK_RESET      8'h00

// -----------------------------------------------------------------------------
// Number formats
// -----------------------------------------------------------------------------
`define FRA_SP_BIAS         12'h07F
`define FRA_DP_BIAS         12'h3FF
`define FRA_SP_CANON_NAN    32'h7FFF_FFFF
`define FRA_DP_CANON_NAN    64'h7FFF_FFFF_FFFF_FFFF
`define FRA_SEED_BITS       8

// -----------------------------------------------------------------------------
// Timing in core cycles from the issue edge
// -----------------------------------------------------------------------------
`define FRA_LAT_LO          1
`define FRA_LAT_HI          2

`endif

// file: rtl/fra_pkg.sv
// Types shared by the reciprocal seed unit.
package fra_pkg;

    typedef enum logic [1:0] {
        OP_SP_RECIP = 2'h0,
        OP_SP_RSQRT = 2'h1,
        OP_DP_RSQRT = 2'h2
    } fra_op_e;

    typedef enum logic [5:0] {
        CLS_NORM   = 6'h01,
        CLS_ZERO   = 6'h02,
        CLS_DENORM = 6'h04,
        CLS_INF    = 6'h08,
        CLS_QNAN   = 6'h10,
        CLS_SNAN   = 6'h20
    } fra_cls_e;

    typedef struct packed {
        logic invalid_op_flag;
        logic second_operand_nan_flag;
        logic divide_by_zero_flag;
        logic infinite_result_flag;
        logic overflow_flag;
        logic inexact_flag;
        logic second_operand_denormal_flag;
        logic underflow_flag;
    } fra_flags_s;

    typedef struct packed {
        logic        valid;
        logic        pred;
        logic        xpath;
        logic [1:0]  op;
        logic [4:0]  dst;
        logic [31:0] src_own;
        logic [31:0] src_cross;
        logic [31:0] src_hi;
    } fra_issue_s;

    typedef struct packed {
        logic        en;
        logic [4:0]  addr;
        logic [31:0] data;
    } fra_wr_s;

    typedef struct packed {
        fra_wr_s     lo;
        fra_wr_s     hi;
        fra_wr_s     hold;
        logic        flags_valid;
        fra_flags_s  flags;
        fra_flags_s  status;
        fra_flags_s  mask;
        logic        irq;
        logic        ack;
        logic [31:0] rdata;
    } fra_state_s;

endpackage : fra_pkg

// file: rtl/fra_seed_core.sv
// Eight-bit mantissa seed and exponent for reciprocal and reciprocal square root.
`timescale 1ns/1ns

module fra_seed_core
    import fra_pkg::*;
(
    input  wire logic               rsqrt,
    input  wire logic signed [11:0] exp_in,
    input  wire logic [7:0]         frac_top,
    input  wire logic               frac_zero,
    output logic signed [11:0]      exp_out,
    output logic [7:0]              mant_out
);

    // -------------------------------------------------------------------------
    // Integer square root, bit by bit
    // -------------------------------------------------------------------------
    function automatic logic [10:0] fra_isqrt(input logic [20:0] v);
        logic [10:0] root;
        logic [21:0] trial;
        root = 11'h000;
        for (int b = 10; b >= 0; b--)
        begin
            trial = 22'((root | (11'h001 << b)) * (root | (11'h001 << b)));
            if (trial <= {1'b0, v})
            begin
                root = root | (11'h001 << b);
            end
        end
        return root;
    endfunction : fra_isqrt

    logic               odd;
    logic signed [11:0] e_even;
    logic [9:0]         d_recip;
    logic [19:0]        q_recip;
    logic [9:0]         r_recip;
    logic [10:0]        y_rsqrt;
    logic [29:0]        q_rsqrt;
    logic [10:0]        s_rsqrt;
    logic [9:0]         r_rsqrt;
    logic               exact;

    // The operand is evaluated at the midpoint of its 8-bit interval, which keeps
    // the seed error inside one and a half units of the last seed bit on either side.
    always_comb
    begin
        odd     = exp_in[0];
        e_even  = exp_in - {11'h000, odd};
        d_recip = {1'b1, frac_top, 1'b1};
        q_recip = 20'h80000 / {10'h000, d_recip};
        r_recip = 10'((q_recip + 20'h00001) >> 1);
        y_rsqrt = odd ? {1'b1, frac_top, 2'h2} : {1'b0, 1'b1, frac_top, 1'b1};
        q_rsqrt = 30'h2000_0000 / {19'h0, y_rsqrt};
        s_rsqrt = fra_isqrt(q_rsqrt[20:0]);
        r_rsqrt = 10'((s_rsqrt + 11'h001) >> 1);
        exact   = frac_zero && (!rsqrt || !odd);
        if (exact)
        begin
            mant_out = 8'h00;
            exp_out  = rsqrt ? -(e_even >>> 1) : -exp_in;
        end
        else if (rsqrt)
        begin
            // Both seeds round to nearest; a root that rounds up to two is held at the
            // largest mantissa, so the exponent computed below stays valid.
            mant_out = r_rsqrt[9] ? 8'hFF : r_rsqrt[7:0];
            exp_out  = -(e_even >>> 1) - 12'sh001;
        end
        else
        begin
            mant_out = r_recip[7:0];
            exp_out  = -exp_in - 12'sh001;
        end
    end

endmodule : fra_seed_core

// file: rtl/fra_unit.sv
// Reciprocal and reciprocal square root seed unit with Wishbone flag registers.
//
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "fra_defines.svh"


module fra_unit
    import fra_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        RESET,
    input  wire fra_issue_s  ISSUE,
    output fra_wr_s          RES_LO,
    output fra_wr_s          RES_HI,
    output logic             FLAGS_VALID,
    output fra_flags_s       FLAGS,
    output logic             IRQ,
    input  wire logic        WB_CYC,
    input  wire logic        WB_STB,
    input  wire logic        WB_WE,
    input  wire logic [7:0]  WB_ADR,
    input  wire logic [3:0]  WB_SEL,
    input  wire logic [31:0] WB_DAT_I,
    output logic [31:0]      WB_DAT_O,
    output logic             WB_ACK
);

    // -------------------------------------------------------------------------
    // Operand classification
    // -------------------------------------------------------------------------
    function automatic fra_cls_e fra_classify(input logic exp_ones, input logic exp_zero,
                                              input logic fzero, input logic fmsb);
        if (exp_ones)
        begin
            return fzero ? CLS_INF : (fmsb ? CLS_QNAN : CLS_SNAN);
        end
        if (exp_zero)
        begin
            return fzero ? CLS_ZERO : CLS_DENORM;
        end
        return CLS_NORM;
    endfunction : fra_classify

    fra_state_s         q;
    fra_state_s         next_q;
    fra_cls_e           cls;
    logic               is_dp;
    logic               is_rsqrt;
    logic               go;
    logic               sign;
    logic [10:0]        exp_b;
    logic               frac_zero;
    logic [7:0]         frac_top;
    logic [31:0]        sp_src;
    logic signed [11:0] exp_unb;
    logic signed [11:0] seed_exp;
    logic [7:0]         seed_mant;
    logic signed [11:0] out_exp;
    logic [63:0]        result;
    fra_flags_s         raise;
    fra_flags_s         clr;
    logic               wb_req;
    logic               wb_commit;

    // -------------------------------------------------------------------------
    // Operand selection and unpacking
    // -------------------------------------------------------------------------
    always_comb
    begin
        is_dp    = (ISSUE.op == OP_DP_RSQRT);
        is_rsqrt = (ISSUE.op == OP_SP_RSQRT) || is_dp;
        // predicate gates every write and flag
        go       = ISSUE.valid && ISSUE.pred && (ISSUE.op != 2'h3);
        // cross path feeds only the SP source
        sp_src   = ISSUE.xpath ? ISSUE.src_cross : ISSUE.src_own;
        if (is_dp)
        begin
            // low word on the own port, high word on the second port
            sign      = ISSUE.src_hi[31];
            exp_b     = ISSUE.src_hi[30:20];
            frac_zero = (ISSUE.src_hi[19:0] == 20'h00000) && (ISSUE.src_own == 32'h0000_0000);
            frac_top  = ISSUE.src_hi[19:12];
            cls       = fra_classify(&exp_b, exp_b == 11'h000, frac_zero, ISSUE.src_hi[19]);
            exp_unb   = $signed({1'b0, exp_b}) - $signed(`FRA_DP_BIAS);
        end
        else
        begin
            sign      = sp_src[31];
            exp_b     = {3'h0, sp_src[30:23]};
            frac_zero = (sp_src[22:0] == 23'h000000);
            frac_top  = sp_src[22:15];
            cls       = fra_classify(&sp_src[30:23], sp_src[30:23] == 8'h00, frac_zero,
                                     sp_src[22]);
            exp_unb   = $signed({1'b0, exp_b}) - $signed(`FRA_SP_BIAS);
        end
    end

    fra_seed_core u_seed (
        .rsqrt     (is_rsqrt),
        .exp_in    (exp_unb),
        .frac_top  (frac_top),
        .frac_zero (frac_zero),
        .exp_out   (seed_exp),
        .mant_out  (seed_mant)
    );

    // -------------------------------------------------------------------------
    // Result and flags
    // -------------------------------------------------------------------------
    // SP results sit in the low 32 bits; the high half is only used by DP.
    always_comb
    begin
        raise   = '0;
        out_exp = seed_exp + (is_dp ? $signed(`FRA_DP_BIAS) : $signed(`FRA_SP_BIAS));
        // exact exponent with an eight-bit seed mantissa
        // same packing for the square root seed
        if (is_dp)
        begin
            result = {sign, out_exp[10:0], seed_mant, 44'h000_0000_0000};
        end
        else
        begin
            result = {32'h0000_0000, sign, out_exp[7:0], seed_mant, 15'h0000};
        end
        unique case (cls)
            CLS_SNAN:
            begin
                result = is_dp ? `FRA_DP_CANON_NAN : {32'h0000_0000, `FRA_SP_CANON_NAN};
                raise.invalid_op_flag         = 1'b1;
                raise.second_operand_nan_flag = 1'b1;
            end
            CLS_QNAN:
            begin
                result = is_dp ? `FRA_DP_CANON_NAN : {32'h0000_0000, `FRA_SP_CANON_NAN};
                raise.second_operand_nan_flag = 1'b1;
            end
            CLS_ZERO:
            begin
                result = is_dp ? {sign, 11'h7FF, 52'h0} : {32'h0, sign, 8'hFF, 23'h0};
                raise.divide_by_zero_flag  = 1'b1;
                raise.infinite_result_flag = 1'b1;
            end
            CLS_DENORM:
            begin
                result = is_dp ? {sign, 11'h7FF, 52'h0} : {32'h0, sign, 8'hFF, 23'h0};
                raise.divide_by_zero_flag          = 1'b1;
                raise.inexact_flag                 = 1'b1;
                raise.second_operand_denormal_flag = 1'b1;
                // the reciprocal also reports infinity and overflow
                // the square root reports only the three above
                raise.infinite_result_flag = !is_rsqrt;
                raise.overflow_flag        = !is_rsqrt;
            end
            CLS_INF:
            begin
                if (is_rsqrt && sign)
                begin
                    // negative infinity is a negative non-zero number
                    result = is_dp ? `FRA_DP_CANON_NAN : {32'h0000_0000, `FRA_SP_CANON_NAN};
                    raise.invalid_op_flag = 1'b1;
                end
                else
                begin
                    // positive zero for the square root
                    result = is_dp ? 64'h0 : {32'h0, sign, 31'h0};
                end
            end
            CLS_NORM:
            begin
                if (is_rsqrt && sign)
                begin
                    // negative normal number to the square root
                    result = is_dp ? `FRA_DP_CANON_NAN : {32'h0000_0000, `FRA_SP_CANON_NAN};
                    raise.invalid_op_flag = 1'b1;
                end
                else if (!is_rsqrt && (out_exp <= 12'sh000))
                begin
                    // magnitude above two to 126 underflows
                    result = {32'h0, sign, 31'h0};
                    raise.inexact_flag   = 1'b1;
                    raise.underflow_flag = 1'b1;
                end
            end
            default:
            begin
                result = 64'h0;
            end
        endcase
    end

    // -------------------------------------------------------------------------
    // Next state: write ports, flags and Wishbone slave
    // -------------------------------------------------------------------------
    always_comb
    begin
        next_q             = q;
        next_q.lo.en       = 1'b0;
        next_q.hold.en     = 1'b0;
        next_q.hi          = q.hold;
        next_q.flags_valid = 1'b0;
        next_q.flags       = '0;
        clr                = '0;
        wb_req             = WB_CYC && WB_STB;
        wb_commit          = wb_req && q.ack;
        if (go)
        begin
            // SP result visible one cycle after the issue edge
            // low word now, high word held one more cycle
            // low word is not delayed behind the high word
            next_q.lo.en       = 1'b1;
            next_q.lo.addr     = is_dp ? {ISSUE.dst[4:1], 1'b0} : ISSUE.dst;
            next_q.lo.data     = result[31:0];
            next_q.hold.en     = is_dp;
            next_q.hold.addr   = {ISSUE.dst[4:1], 1'b1};
            next_q.hold.data   = result[63:32];
            next_q.flags_valid = 1'b1;
            next_q.flags       = raise;
        end
        // Acknowledge one cycle after the request; drop ack the cycle after.
        next_q.ack = wb_req && !q.ack;
        if (wb_req && !q.ack)
        begin
            unique case (WB_ADR)
                `FRA_REG_STATUS: next_q.rdata = {24'h000000, q.status};
                `FRA_REG_MASK:   next_q.rdata = {24'h000000, q.mask};
                default:         next_q.rdata = 32'h0000_0000;
            endcase
        end
        if (wb_commit && WB_WE && WB_SEL[0])
        begin
            if (WB_ADR == `FRA_REG_STATUS)
            begin
                clr = WB_DAT_I[7:0];
            end
            if (WB_ADR == `FRA_REG_MASK)
            begin
                next_q.mask = WB_DAT_I[7:0];
            end
        end
        // A flag raised in the same cycle as its clear stays set.
        next_q.status = (q.status & ~clr) | next_q.flags;
        next_q.irq    = |(next_q.status & next_q.mask);
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            q        <= '0;
            q.status <= `FRA_FLAGS_RESET;
            q.mask   <= `FRA_MASK_RESET;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign RES_LO      = q.lo;
    assign RES_HI      = q.hi;
    assign FLAGS_VALID = q.flags_valid;
    assign FLAGS       = q.flags;
    assign IRQ         = q.irq;
    assign WB_DAT_O    = q.rdata;
    assign WB_ACK      = q.ack;

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RESET);

    sequence s_dp_issue;
        go && is_dp;
    endsequence

    sequence s_dp_words;
        RES_LO.en && !RES_LO.addr[0] ##1 RES_HI.en && RES_HI.addr[0];
    endsequence

    chk_sp_one_cycle: assert property (
        go && !is_dp |=> RES_LO.en && !q.hold.en && FLAGS_VALID)
        else $error("SP result not written one cycle after issue");

    chk_dp_two_words: assert property (
        s_dp_issue |=> s_dp_words)
        else $error("DP words not written in stages one and two");

    chk_dp_lo_first: assert property (
        s_dp_issue |=> RES_LO.en && q.hold.en
                       ##1 RES_HI.en && RES_HI.addr == {$past(RES_LO.addr[4:1]), 1'b1})
        else $error("DP high word not one cycle after low word");

    chk_pred_noop: assert property (
        !(ISSUE.valid && ISSUE.pred)
        |=> !RES_LO.en && !FLAGS_VALID && (q.status & ~$past(q.status)) == 8'h00)
        else $error("False predicate changed results or flags");

    chk_snan_flags: assert property (
        go && cls == CLS_SNAN |=> FLAGS.invalid_op_flag && FLAGS.second_operand_nan_flag
                                 && RES_LO.data == ($past(is_dp) ? 32'(`FRA_DP_CANON_NAN)
                                                                 : `FRA_SP_CANON_NAN))
        else $error("Signalling NaN not handled");

    chk_qnan_flags: assert property (
        go && cls == CLS_QNAN |=> FLAGS == 8'h40)
        else $error("Quiet NaN raised wrong flags");

    chk_zero_inf: assert property (
        go && cls == CLS_ZERO && !is_dp
        |=> RES_LO.data[30:0] == 31'h7F80_0000 && FLAGS == 8'h30)
        else $error("Zero source did not give infinity");

    chk_recip_inf: assert property (
        go && cls == CLS_INF && !is_rsqrt |=> RES_LO.data[30:0] == 31'h0 && FLAGS == 8'h00)
        else $error("Reciprocal of infinity not zero");

    chk_recip_under: assert property (
        go && !is_rsqrt && cls == CLS_NORM && sp_src[30:23] > 8'hFD
        |=> RES_LO.data[30:0] == 31'h0 && FLAGS == 8'h05)
        else $error("Reciprocal underflow not flagged");

    chk_rsqrt_neg: assert property (
        go && is_rsqrt && sign && (cls == CLS_NORM || cls == CLS_INF)
        |=> FLAGS == 8'h80)
        else $error("Negative square root source not invalid");

    chk_denorm_flags: assert property (
        go && is_rsqrt && cls == CLS_DENORM |=> FLAGS == 8'h26)
        else $error("Square root of denormal raised wrong flags");

    chk_recip_denorm: assert property (
        go && !is_rsqrt && cls == CLS_DENORM |=> FLAGS == 8'h3E)
        else $error("Reciprocal of denormal raised wrong flags");

    chk_recip_exp: assert property (
        go && !is_rsqrt && cls == CLS_NORM && frac_zero && sp_src[30:23] < 8'hFD
        |=> RES_LO.data[30:23] == 8'(8'hFE - $past(sp_src[30:23])) && RES_LO.data[22:0] == 0)
        else $error("Reciprocal of power of two not exact");

    chk_irq_level: assert property (
        IRQ == |($past(next_q.status) & $past(next_q.mask)))
        else $error("Interrupt does not follow masked status");

endmodule : fra_unit

// file: verification/fra_regfile.sv
// Register file model that keeps what the seed unit writes back.
`timescale 1ns/1ns
module fra_regfile
    import fra_pkg::*;
(
    input wire logic    clk,
    input wire fra_wr_s lo,
    input wire fra_wr_s hi
);
    logic [31:0] rf [32];
    always_ff @(posedge clk)
    begin
        if (lo.en)
            rf[lo.addr] <= lo.data;
        if (hi.en)
            rf[hi.addr] <= hi.data;
    end
endmodule : fra_regfile

// file: verification/fra_unit_tb_top.sv
// Self-checking bench for the reciprocal seed unit.
`timescale 1ns/1ns
module fra_unit_tb_top;
    import fra_pkg::*;
    logic        CLK_SYS;
    logic        RESET;
    fra_issue_s  ISSUE;
    fra_wr_s     RES_LO;
    fra_wr_s     RES_HI;
    logic        FLAGS_VALID;
    fra_flags_s  FLAGS;
    logic        IRQ;
    logic        WB_CYC;
    logic        WB_STB;
    logic        WB_WE;
    logic [7:0]  WB_ADR;
    logic [3:0]  WB_SEL;
    logic [31:0] WB_DAT_I;
    logic [31:0] WB_DAT_O;
    logic        WB_ACK;
    logic [31:0] rd;
    int          errors;
    int          check_count;

    fra_unit DUT (.CLK_SYS, .RESET, .ISSUE, .RES_LO, .RES_HI, .FLAGS_VALID, .FLAGS, .IRQ,
        .WB_CYC, .WB_STB, .WB_WE, .WB_ADR, .WB_SEL, .WB_DAT_I, .WB_DAT_O, .WB_ACK);
    fra_regfile PART (.clk(CLK_SYS), .lo(RES_LO), .hi(RES_HI));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic cmp(input logic [63:0] a, input logic [63:0] e);
        check_count++;
        if (a !== e)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, a, e);
        end
    endtask : cmp

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        {WB_CYC, WB_STB, WB_WE, WB_ADR, WB_DAT_I} <= {2'b11, we, a, d};
        do
        begin
            @(posedge CLK_SYS);
        end
        while (WB_ACK !== 1'b1);
        rd = WB_DAT_O;
        {WB_CYC, WB_STB} <= 2'b00;
    endtask : wb

    // Cross source carries the operand; the own source carries its inverse when x is set, the operand itself otherwise.
    task automatic go(input logic p, x, input logic [1:0] op, input logic [31:0] s, h);
        @(posedge CLK_SYS);
        ISSUE <= '{1'b1, p, x, op, 5'h07, x ? ~s : s, s, h};
        @(posedge CLK_SYS);
        ISSUE.valid <= 1'b0;
        #1;
    endtask : go

    task automatic sp(input logic x, input logic [1:0] op, input logic [31:0] s, e,
                      input logic [7:0] f);
        go(1'b1, x, op, s, 32'h0);
        cmp({RES_LO, FLAGS_VALID, FLAGS, RES_HI.en}, {1'b1, 5'h07, e, 1'b1, f, 1'b0});
    endtask : sp

    task automatic dp(input logic [31:0] h, l, eh, el, input logic [7:0] f);
        go(1'b1, 1'b0, 2'h2, l, h);
        cmp({RES_LO, FLAGS_VALID, FLAGS, RES_HI.en}, {1'b1, 5'h06, el, 1'b1, f, 1'b0});
        @(posedge CLK_SYS);
        #1;
        cmp({RES_HI, RES_LO.en, FLAGS_VALID}, {1'b1, 5'h07, eh, 2'b00});
    endtask : dp

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        wb(1'b0, 8'h00, 32'h0);
        cmp(rd, 64'h0);
        wb(1'b0, 8'h04, 32'h0);
        cmp(rd, 64'h0);
        wb(1'b1, 8'h08, 32'hFF);
        wb(1'b0, 8'h08, 32'h0);
        cmp(rd, 64'h0);
        $display("t_regs done");
    endtask : t_regs

    task automatic t_irq;
        sp(1'b0, 2'h0, 32'h0000_0000, 32'h7F80_0000, 8'h30);
        cmp(IRQ, 64'h0);
        wb(1'b1, 8'h04, 32'h10);
        repeat (2) @(posedge CLK_SYS);
        #1;
        cmp(IRQ, 64'h1);
        wb(1'b0, 8'h00, 32'h0);
        cmp(rd, 64'h30);
        wb(1'b1, 8'h00, 32'h10);
        repeat (2) @(posedge CLK_SYS);
        #1;
        cmp(IRQ, 64'h0);
        wb(1'b0, 8'h00, 32'h0);
        cmp(rd, 64'h20);
        wb(1'b0, 8'h04, 32'h0);
        cmp(rd, 64'h10);
        wb(1'b1, 8'h04, 32'h0);
        wb(1'b1, 8'h00, 32'hFF);
        $display("t_irq done");
    endtask : t_irq

    task automatic t_sp;
        sp(1'b0, 2'h0, 32'h4080_0000, 32'h3E80_0000, 8'h00);
        sp(1'b1, 2'h0, 32'h3F00_0000, 32'h4000_0000, 8'h00);
        sp(1'b0, 2'h1, 32'h4080_0000, 32'h3F00_0000, 8'h00);
        sp(1'b1, 2'h1, 32'h4180_0000, 32'h3E80_0000, 8'h00);
        sp(1'b1, 2'h1, 32'h4109_999A, 32'h3EAE_8000, 8'h00);
        sp(1'b0, 2'h0, 32'h4040_0000, 32'h3EAA_8000, 8'h00);
        sp(1'b0, 2'h0, 32'h7FA0_0000, 32'h7FFF_FFFF, 8'hC0);
        sp(1'b0, 2'h1, 32'h7FC0_0000, 32'h7FFF_FFFF, 8'h40);
        sp(1'b0, 2'h0, 32'h8000_0001, 32'hFF80_0000, 8'h3E);
        sp(1'b0, 2'h1, 32'h8000_0000, 32'hFF80_0000, 8'h30);
        sp(1'b0, 2'h0, 32'hFF80_0000, 32'h8000_0000, 8'h00);
        sp(1'b0, 2'h0, 32'hFF00_0000, 32'h8000_0000, 8'h05);
        sp(1'b0, 2'h1, 32'hC080_0000, 32'h7FFF_FFFF, 8'h80);
        sp(1'b0, 2'h1, 32'h0000_0001, 32'h7F80_0000, 8'h26);
        sp(1'b0, 2'h1, 32'h7F80_0000, 32'h0000_0000, 8'h00);
        $display("t_sp done");
    endtask : t_sp

    task automatic t_dp;
        dp(32'h4010_0000, 32'h0, 32'h3FE0_0000, 32'h0, 8'h00);
        @(posedge CLK_SYS);
        #1;
        cmp({PART.rf[7], PART.rf[6]}, 64'h3FE0_0000_0000_0000);
        dp(32'h7FF4_0000, 32'h0, 32'h7FFF_FFFF, 32'hFFFF_FFFF, 8'hC0);
        dp(32'h8000_0000, 32'h1, 32'hFFF0_0000, 32'h0, 8'h26);
        dp(32'hC010_0000, 32'h0, 32'h7FFF_FFFF, 32'hFFFF_FFFF, 8'h80);
        dp(32'h7FF0_0000, 32'h0, 32'h0, 32'h0, 8'h00);
        $display("t_dp done");
    endtask : t_dp

    task automatic t_pred;
        wb(1'b1, 8'h00, 32'hFF);
        go(1'b0, 1'b0, 2'h0, 32'h7FA0_0000, 32'h0);
        cmp({RES_LO.en, FLAGS_VALID, FLAGS}, 64'h0);
        go(1'b0, 1'b0, 2'h2, 32'h0, 32'h7FF4_0000);
        @(posedge CLK_SYS);
        #1;
        cmp({RES_LO.en, RES_HI.en, FLAGS_VALID}, 64'h0);
        wb(1'b0, 8'h00, 32'h0);
        cmp(rd, 64'h0);
        $display("t_pred done");
    endtask : t_pred

    task automatic results;
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results

    initial
    begin
        CLK_SYS = 1'b0;
        forever #2 CLK_SYS = ~CLK_SYS;
    end

    initial
    begin
        errors = 0;
        check_count = 0;
        RESET = 1'b1;
        ISSUE = '0;
        {WB_CYC, WB_STB, WB_WE, WB_ADR, WB_DAT_I} = '0;
        WB_SEL = 4'hF;
        repeat (5) @(posedge CLK_SYS);
        RESET <= 1'b0;
        t_regs();
        t_irq();
        t_sp();
        t_dp();
        t_pred();
        results();
    end

    // The whole sequence needs well under a thousand cycles.
    initial
    begin
        #40000;
        errors++;
        results();
    end
endmodule : fra_unit_tb_top
